// [trp_consts.svh]
/*
  Constants of the two-channel reload timer with toggle and PWM outputs:
  register offsets, field positions, reset values and divider masks.
  Assumes it is included by its bare name from the package and modules.
*/
// Behaviour
// - Fast source: tick at clock/128 down to clock/1 for rate codes 0..7
// - Eight-bit counter wraps 0xff to 0x00; one overflow per 256 ticks
// - Auto-reload copies the reload register into the counter at overflow
// - PWM mode reloads by itself; auto-reload bit then picks the boundary
// - Reload register is write-only, zero after reset; software writes whole values
// - Toggle output inverts at every overflow: half the overflow rate
// - Toggle output drives the pin and takes it from general-purpose I/O
// - Clearing run stops counting, toggle output and PWM output
// - PWM output falls when counter equals reload value
// - PWM output goes high when counter wraps to zero, unless reload is zero
// - PWM duty is reload/256, from 0/256 to 255/256
// - PWM high while counter below reload, low when equal or above
// - Counter write changes the PWM level at once; fixed reload gives steady waveform
// - Channel one PWM drives its pin and displaces general-purpose I/O
// - Channel zero gives the same PWM from its own counter and reload
// - In PWM mode without auto-reload the interrupt request still fires at the overflow boundary
// - Overflow keeps counting and sets the interrupt request flag, except in PWM mode with auto-reload
// - Mode: run bit 7, rate 6:4, auto-reload 2, toggle 1, PWM 0
// - Slow source: tick at instruction clock/256 down to /2 for codes 0..7
`ifndef TRP_CONSTS_SVH
`define TRP_CONSTS_SVH

`define TRP_ADDR_FAST_SEL 8'hd8
`define TRP_ADDR_ONE_MODE 8'hdc
`define TRP_ADDR_ONE_COUNT 8'hdd
`define TRP_ADDR_ONE_RELOAD 8'hde
`define TRP_ADDR_ZERO_MODE 8'hda
`define TRP_ADDR_ZERO_COUNT 8'hdb
`define TRP_ADDR_ZERO_RELOAD 8'hcd
`define TRP_ADDR_IRQ_FLAG 8'hc8
`define TRP_ADDR_IRQ_EN 8'hc9

`define TRP_BIT_RUN 7
`define TRP_BIT_RATE_HI 6
`define TRP_BIT_RATE_LO 4
`define TRP_BIT_ALOAD 2
`define TRP_BIT_TOGGLE 1
`define TRP_BIT_PWM 0
`define TRP_BIT_FAST_ONE 3
`define TRP_BIT_FAST_ZERO 2

`define TRP_MODE_MASK 8'hf7
`define TRP_MODE_RESET 8'h00
`define TRP_RELOAD_RESET 8'h00
`define TRP_COUNT_RESET 8'h00
`define TRP_COUNT_WRAP 8'hff
`define TRP_FAST_MASK 8'h7f
`define TRP_SLOW_MASK 8'hff

`endif

// [trp_pkg.sv]
/*
  Types shared by the timer channel files and the divider mask function.
  Assumes trp_consts.svh is on the include path.
*/
`include "trp_consts.svh"
package trp_pkg;
  typedef struct packed {
    logic run;
    logic [2:0] rate;
    logic aload;
    logic tog_en;
    logic pwm_en;
    logic fast;
  } trp_cfg_t;

  typedef struct packed {
    logic level;
    logic oe;
    logic gpio_off;
  } trp_pin_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } trp_bus_t;

  function automatic logic [7:0] trp_rate_mask(input logic fast, input logic [2:0] rate);
    trp_rate_mask = fast ? (`TRP_FAST_MASK >> rate) : (`TRP_SLOW_MASK >> rate);
  endfunction : trp_rate_mask
endpackage : trp_pkg

// [trp_prescale.sv]
/*
  Rate prescaler of one channel: a one-cycle tick enable per timer step.
  Assumes cpu_tick is a one-cycle pulse at the instruction clock rate.
*/
`timescale 1ns/1ps
module trp_prescale (
  input wire logic clock,
  input wire logic srst,
  input wire logic cpu_tick,
  input wire trp_pkg::trp_cfg_t cfg,
  output logic tick
);
  typedef struct packed {
    logic [7:0] pre;
  } trp_pre_st_t;

  trp_pre_st_t st_q;
  trp_pre_st_t st_d;
  logic inc;
  logic [7:0] mask;

  assign inc = cfg.fast | cpu_tick;
  assign mask = trp_pkg::trp_rate_mask(cfg.fast, cfg.rate);
  assign tick = cfg.run & inc & ((st_q.pre & mask) == mask);

  always_comb begin
    st_d = st_q;
    if (!cfg.run) begin
      st_d.pre = 8'h00;
    end else if (inc) begin
      st_d.pre = st_q.pre + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : trp_prescale

// [trp_chan.sv]
/*
  Counter, reload, toggle and PWM stage of one timer channel.
  Assumes tick is a one-cycle enable from the prescaler.
*/
`timescale 1ns/1ps
`include "trp_consts.svh"
module trp_chan (
  input wire logic clock,
  input wire logic srst,
  input wire trp_pkg::trp_cfg_t cfg,
  input wire logic tick,
  input wire logic [7:0] reload,
  input wire logic cnt_wr,
  input wire logic [7:0] cnt_wdata,
  output logic [7:0] count,
  output logic evt,
  output trp_pkg::trp_pin_t pin
);
  typedef struct packed {
    logic [7:0] count;
    logic tog;
    logic level;
  } trp_chan_st_t;

  trp_chan_st_t st_q;
  trp_chan_st_t st_d;
  logic [7:0] step;
  logic wrap;

  assign step = st_q.count + 8'h01;
  assign wrap = tick && (st_q.count == `TRP_COUNT_WRAP);
  // Auto-reload in PWM mode moves the request to the duty edge
  assign evt = (cfg.pwm_en && cfg.aload) ? (tick && !cnt_wr && step == reload)
                                         : wrap;

  always_comb begin
    st_d = st_q;
    if (cnt_wr) begin
      st_d.count = cnt_wdata;
    end else if (wrap) begin
      if (cfg.pwm_en) begin
        st_d.count = `TRP_COUNT_RESET;
      end else if (cfg.aload) begin
        st_d.count = reload;
      end else begin
        st_d.count = step;
      end
    end else if (tick) begin
      st_d.count = step;
    end
    if (!cfg.run) begin
      st_d.tog = 1'b0;
    end else if (wrap && cfg.tog_en && !cfg.pwm_en) begin
      st_d.tog = ~st_q.tog;
    end
    if (!cfg.run) begin
      st_d.level = 1'b0;
    end else if (cfg.pwm_en) begin
      st_d.level = st_d.count < reload;
    end else if (cfg.tog_en) begin
      st_d.level = st_d.tog;
    end else begin
      st_d.level = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count = st_q.count;
  assign pin.level = st_q.level;
  assign pin.oe = cfg.pwm_en | cfg.tog_en;
  assign pin.gpio_off = cfg.pwm_en | cfg.tog_en;
endmodule : trp_chan

// [trp_top.sv]
/*
  Two-channel eight-bit reload timer with toggle and PWM pin outputs.
  Holds the register file, the request flags and both channels.
  Assumes a one-cycle register strobe bus and an instruction-clock pulse.
*/
`timescale 1ns/1ps
`include "trp_consts.svh"
module trp_top (
  input wire logic clock,
  input wire logic srst,
  input wire logic cpu_tick,
  input wire trp_pkg::trp_bus_t bus,
  output logic [7:0] rdata,
  output trp_pkg::trp_pin_t one_pin,
  output trp_pkg::trp_pin_t zero_pin,
  output logic [1:0] irq_req
);
  typedef struct packed {
    logic [1:0][7:0] mode;
    logic [1:0][7:0] reload;
    logic [1:0] fast;
    logic [1:0] flag;
    logic [1:0] ien;
    logic [7:0] rdata;
  } trp_reg_st_t;

  trp_reg_st_t st_q;
  trp_reg_st_t st_d;
  trp_pkg::trp_cfg_t [1:0] cfg;
  trp_pkg::trp_pin_t [1:0] pin;
  logic [1:0] tick;
  logic [1:0] evt;
  logic [1:0] cnt_wr;
  logic [1:0][7:0] count;
  logic [1:0] flag_clr;

  function automatic logic hit(input trp_pkg::trp_bus_t b, input logic [7:0] a);
    hit = b.wr && (b.addr == a);
  endfunction : hit

  assign cnt_wr[1] = hit(bus, `TRP_ADDR_ONE_COUNT);
  assign cnt_wr[0] = hit(bus, `TRP_ADDR_ZERO_COUNT);
  // A zero written to a flag bit clears it
  assign flag_clr = hit(bus, `TRP_ADDR_IRQ_FLAG) ? ~bus.wdata[1:0] : 2'h0;

  always_comb begin
    st_d = st_q;
    st_d.rdata = 8'h00;
    st_d.flag = (st_q.flag & ~flag_clr) | evt;
    if (bus.wr) begin
      case (bus.addr)
        `TRP_ADDR_ONE_MODE: begin
          st_d.mode[1] = bus.wdata & `TRP_MODE_MASK;
        end
        `TRP_ADDR_ZERO_MODE: begin
          st_d.mode[0] = bus.wdata & `TRP_MODE_MASK;
        end
        `TRP_ADDR_ONE_RELOAD: begin
          st_d.reload[1] = bus.wdata;
        end
        `TRP_ADDR_ZERO_RELOAD: begin
          st_d.reload[0] = bus.wdata;
        end
        `TRP_ADDR_FAST_SEL: begin
          st_d.fast[1] = bus.wdata[`TRP_BIT_FAST_ONE];
          st_d.fast[0] = bus.wdata[`TRP_BIT_FAST_ZERO];
        end
        `TRP_ADDR_IRQ_EN: begin
          st_d.ien = bus.wdata[1:0];
        end
        default: begin
          st_d.ien = st_q.ien;
        end
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        `TRP_ADDR_ONE_MODE: begin
          st_d.rdata = st_q.mode[1];
        end
        `TRP_ADDR_ZERO_MODE: begin
          st_d.rdata = st_q.mode[0];
        end
        `TRP_ADDR_ONE_COUNT: begin
          st_d.rdata = count[1];
        end
        `TRP_ADDR_ZERO_COUNT: begin
          st_d.rdata = count[0];
        end
        `TRP_ADDR_FAST_SEL: begin
          st_d.rdata[`TRP_BIT_FAST_ONE] = st_q.fast[1];
          st_d.rdata[`TRP_BIT_FAST_ZERO] = st_q.fast[0];
        end
        `TRP_ADDR_IRQ_FLAG: begin
          st_d.rdata = {6'h00, st_q.flag};
        end
        `TRP_ADDR_IRQ_EN: begin
          st_d.rdata = {6'h00, st_q.ien};
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end
    if (srst) begin
      st_d.mode = {`TRP_MODE_RESET, `TRP_MODE_RESET};
      st_d.reload = {`TRP_RELOAD_RESET, `TRP_RELOAD_RESET};
      st_d.fast = 2'h0;
      st_d.flag = 2'h0;
      st_d.ien = 2'h0;
      st_d.rdata = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  assign rdata = st_q.rdata;
  assign irq_req = st_q.flag & st_q.ien;
  assign one_pin = pin[1];
  assign zero_pin = pin[0];

  for (genvar g = 0; g < 2; g++) begin : g_chan
    assign cfg[g].run = st_q.mode[g][`TRP_BIT_RUN];
    assign cfg[g].rate = st_q.mode[g][`TRP_BIT_RATE_HI:`TRP_BIT_RATE_LO];
    assign cfg[g].aload = st_q.mode[g][`TRP_BIT_ALOAD];
    assign cfg[g].tog_en = st_q.mode[g][`TRP_BIT_TOGGLE];
    assign cfg[g].pwm_en = st_q.mode[g][`TRP_BIT_PWM];
    assign cfg[g].fast = st_q.fast[g];

    trp_prescale u_pre (
      .clock(clock),
      .srst(srst),
      .cpu_tick(cpu_tick),
      .cfg(cfg[g]),
      .tick(tick[g])
    );

    trp_chan u_chan (
      .clock(clock),
      .srst(srst),
      .cfg(cfg[g]),
      .tick(tick[g]),
      .reload(st_q.reload[g]),
      .cnt_wr(cnt_wr[g]),
      .cnt_wdata(bus.wdata),
      .count(count[g]),
      .evt(evt[g]),
      .pin(pin[g])
    );

    a_fast_full_rate: assert property (
      @(posedge clock) disable iff (srst)
      (cfg[g].run && cfg[g].fast && cfg[g].rate == 3'h7) |-> tick[g])
      else $error("fast source at rate 7 missed a tick");

    a_fast_div_two: assert property (
      @(posedge clock) disable iff (srst)
      (tick[g] && cfg[g].fast && cfg[g].rate == 3'h6) ##1 $stable(cfg[g])
        |-> !tick[g] ##1 (!$stable(cfg[g]) || tick[g]))
      else $error("fast divide by two spacing wrong");

    a_slow_needs_cpu: assert property (
      @(posedge clock) disable iff (srst)
      (tick[g] && !cfg[g].fast) |-> cpu_tick)
      else $error("slow source ticked without instruction clock");

    a_count_step: assert property (
      @(posedge clock) disable iff (srst)
      (tick[g] && !cnt_wr[g] && count[g] != 8'hff) |=> count[g] == $past(count[g]) + 8'h01)
      else $error("counter did not step by one");

    a_count_wrap: assert property (
      @(posedge clock) disable iff (srst)
      (tick[g] && !cnt_wr[g] && count[g] == 8'hff && !cfg[g].aload) |=> count[g] == 8'h00)
      else $error("counter did not wrap to zero");

    a_auto_reload: assert property (
      @(posedge clock) disable iff (srst)
      (tick[g] && !cnt_wr[g] && count[g] == 8'hff && cfg[g].aload && !cfg[g].pwm_en)
        |=> count[g] == $past(st_q.reload[g]))
      else $error("reload value not copied at overflow");

    a_pwm_restart: assert property (
      @(posedge clock) disable iff (srst)
      (tick[g] && !cnt_wr[g] && count[g] == 8'hff && cfg[g].pwm_en) |=> count[g] == 8'h00)
      else $error("PWM cycle did not restart at zero");

    a_reload_write: assert property (
      @(posedge clock) disable iff (srst)
      hit(bus, g == 1 ? `TRP_ADDR_ONE_RELOAD : `TRP_ADDR_ZERO_RELOAD)
        |=> st_q.reload[g] == $past(bus.wdata))
      else $error("reload write not stored");

    a_toggle_flip: assert property (
      @(posedge clock) disable iff (srst)
      ($stable(cfg[g]) && cfg[g].run && cfg[g].tog_en && !cfg[g].pwm_en && tick[g]
        && count[g] == 8'hff)
        ##1 $stable(cfg[g]) |-> pin[g].level != $past(pin[g].level))
      else $error("toggle output did not invert at overflow");

    a_toggle_hold: assert property (
      @(posedge clock) disable iff (srst)
      ($stable(cfg[g]) && cfg[g].run && cfg[g].tog_en && !cfg[g].pwm_en
        && !(tick[g] && count[g] == 8'hff))
        ##1 $stable(cfg[g]) |-> $stable(pin[g].level))
      else $error("toggle output changed between overflows");

    a_pin_taken: assert property (
      @(posedge clock) disable iff (srst)
      (cfg[g].tog_en || cfg[g].pwm_en) |-> (pin[g].oe && pin[g].gpio_off))
      else $error("pin not taken from general-purpose I/O");

    a_stop_low: assert property (
      @(posedge clock) disable iff (srst)
      !cfg[g].run |=> !pin[g].level)
      else $error("output not stopped when run cleared");

    a_stop_count: assert property (
      @(posedge clock) disable iff (srst)
      (!cfg[g].run && !cnt_wr[g]) |=> count[g] == $past(count[g]))
      else $error("counter moved while stopped");

    a_pwm_compare: assert property (
      @(posedge clock) disable iff (srst)
      ($past(cfg[g].run && cfg[g].pwm_en) && $stable(st_q.reload[g]) && !$past(srst))
        |-> pin[g].level == (count[g] < st_q.reload[g]))
      else $error("PWM level disagrees with compare");

    a_pwm_zero_high: assert property (
      @(posedge clock) disable iff (srst)
      (cfg[g].run && cfg[g].pwm_en && tick[g] && count[g] == 8'hff && !cnt_wr[g]
        && st_q.reload[g] != 8'h00) ##1 $stable(cfg[g]) |-> pin[g].level)
      else $error("PWM not high at cycle start");

    a_pwm_zero_duty: assert property (
      @(posedge clock) disable iff (srst)
      (cfg[g].run && cfg[g].pwm_en && st_q.reload[g] == 8'h00) [*2] |-> !pin[g].level)
      else $error("zero duty produced a high level");

    a_count_write: assert property (
      @(posedge clock) disable iff (srst)
      cnt_wr[g] |=> count[g] == $past(bus.wdata))
      else $error("counter write not applied at once");

    a_flag_set: assert property (
      @(posedge clock) disable iff (srst)
      evt[g] |=> st_q.flag[g])
      else $error("request flag not set by overflow, clear may not win");

    a_flag_clear: assert property (
      @(posedge clock) disable iff (srst)
      (hit(bus, `TRP_ADDR_IRQ_FLAG) && !bus.wdata[g] && !evt[g]) |=> !st_q.flag[g])
      else $error("request flag not cleared");

    a_irq_gate: assert property (
      @(posedge clock) disable iff (srst)
      irq_req[g] == (st_q.flag[g] && st_q.ien[g]))
      else $error("interrupt output not gated by enable");

    a_stop_no_tick: assert property (
      @(posedge clock) disable iff (srst)
      !cfg[g].run |-> !tick[g])
      else $error("prescaler ticked while stopped");

    a_evt_at_wrap: assert property (
      @(posedge clock) disable iff (srst)
      !cfg[g].pwm_en |-> evt[g] == (tick[g] && count[g] == 8'hff))
      else $error("timer request not at overflow");

    a_pwm_irq_wrap: assert property (
      @(posedge clock) disable iff (srst)
      (cfg[g].pwm_en && !cfg[g].aload) |-> evt[g] == (tick[g] && count[g] == 8'hff))
      else $error("PWM request not at cycle wrap");

    a_pwm_irq_duty: assert property (
      @(posedge clock) disable iff (srst)
      (cfg[g].pwm_en && cfg[g].aload && tick[g] && !cnt_wr[g])
        |-> evt[g] == (count[g] + 8'h01 == st_q.reload[g]))
      else $error("PWM request not at duty edge");

    a_pwm_match_low: assert property (
      @(posedge clock) disable iff (srst)
      (cfg[g].run && cfg[g].pwm_en && tick[g] && !cnt_wr[g]
        && count[g] + 8'h01 == st_q.reload[g]) ##1 $stable(cfg[g]) |-> !pin[g].level)
      else $error("PWM not low at compare match");

    a_toggle_off_low: assert property (
      @(posedge clock) disable iff (srst)
      (cfg[g].run && !cfg[g].pwm_en && !cfg[g].tog_en) |=> !pin[g].level)
      else $error("pin level driven with no output function");

    a_count_read: assert property (
      @(posedge clock) disable iff (srst)
      (bus.rd && bus.addr == (g == 1 ? `TRP_ADDR_ONE_COUNT : `TRP_ADDR_ZERO_COUNT))
        |=> rdata == $past(count[g]))
      else $error("counter read mismatch");

    a_reload_hold: assert property (
      @(posedge clock) disable iff (srst)
      !hit(bus, g == 1 ? `TRP_ADDR_ONE_RELOAD : `TRP_ADDR_ZERO_RELOAD)
        |=> st_q.reload[g] == $past(st_q.reload[g]))
      else $error("reload register changed without a write");
  end

  a_reload_read_zero: assert property (
    @(posedge clock) disable iff (srst)
    (bus.rd && (bus.addr == `TRP_ADDR_ONE_RELOAD || bus.addr == `TRP_ADDR_ZERO_RELOAD))
      |=> rdata == 8'h00)
    else $error("write-only reload register read back data");

  a_mode_read: assert property (
    @(posedge clock) disable iff (srst)
    (bus.rd && bus.addr == `TRP_ADDR_ONE_MODE && !bus.wr) |=> rdata == st_q.mode[1])
    else $error("mode register read mismatch");

  a_mode_reserved: assert property (
    @(posedge clock) disable iff (srst)
    st_q.mode[1][3] == 1'b0 && st_q.mode[0][3] == 1'b0)
    else $error("reserved mode bit stored");

  a_reset_state: assert property (
    @(posedge clock)
    srst |=> (st_q.reload == 16'h0000 && st_q.mode == 16'h0000 && rdata == 8'h00))
    else $error("registers not cleared by reset");

  a_reset_pins: assert property (
    @(posedge clock)
    srst |=> (!one_pin.level && !zero_pin.level))
    else $error("pin outputs not low after reset");

  a_ien_write: assert property (
    @(posedge clock) disable iff (srst)
    hit(bus, `TRP_ADDR_IRQ_EN) |=> st_q.ien == $past(bus.wdata[1:0]))
    else $error("interrupt enable write not stored");

  a_fast_write: assert property (
    @(posedge clock) disable iff (srst)
    hit(bus, `TRP_ADDR_FAST_SEL) |=> st_q.fast
      == {$past(bus.wdata[`TRP_BIT_FAST_ONE]), $past(bus.wdata[`TRP_BIT_FAST_ZERO])})
    else $error("fast source select write not stored");

  a_mode_write: assert property (
    @(posedge clock) disable iff (srst)
    hit(bus, `TRP_ADDR_ONE_MODE) |=> st_q.mode[1] == ($past(bus.wdata) & `TRP_MODE_MASK))
    else $error("mode write not stored");

  a_rdata_idle: assert property (
    @(posedge clock) disable iff (srst)
    !bus.rd |=> rdata == 8'h00)
    else $error("read data stood beyond one cycle");
endmodule : trp_top

// [trp_pin_load.sv]
/*
  Load on one timer pin: counts high samples and the gap between level changes.
  Assumes a pull-up holds the pad high while the timer does not drive it.
*/
`timescale 1ns/1ps
module trp_pin_load (
  input wire logic clock,
  input wire logic clr,
  input wire trp_pkg::trp_pin_t pin,
  output logic [15:0] high_cnt,
  output logic [15:0] last_gap
);
  logic pad;
  logic pad_q;
  logic [15:0] gap_q;
  // Pad follows the timer only while it drives it
  assign pad = pin.oe ? pin.level : 1'b1;
  always @(posedge clock) begin
    pad_q <= pad;
    if (clr) begin
      high_cnt <= 16'h0000;
      gap_q <= 16'h0001;
      last_gap <= 16'h0000;
    end else begin
      high_cnt <= high_cnt + {15'h0000, pad};
      gap_q <= (pad != pad_q) ? 16'h0001 : gap_q + 16'h0001;
      if (pad != pad_q) begin
        last_gap <= gap_q;
      end
    end
  end
endmodule : trp_pin_load

// [timer_reload_toggle_pwm_tb.sv]
/*
  Self-checking bench of the two-channel reload timer with pin loads.
  Assumes trp_pkg, trp_top and trp_pin_load are compiled before it.
*/
`timescale 1ns/1ps
module timer_reload_toggle_pwm_tb;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic cpu_tick = 1'b0;
  logic [1:0] div_q = 2'h0;
  trp_pkg::trp_bus_t bus = '0;
  logic [7:0] rdata;
  trp_pkg::trp_pin_t one_pin;
  trp_pkg::trp_pin_t zero_pin;
  logic [1:0] irq_req;
  logic clr = 1'b0;
  logic [15:0] one_high, one_gap, zero_high, zero_gap;
  int miscompares = 0;
  int cmp_count = 0;

  always #5 clock = ~clock;
  // Instruction clock runs at a quarter of the system clock
  always @(posedge clock) begin
    div_q <= div_q + 2'h1;
    cpu_tick <= (div_q == 2'h3);
  end

  trp_top DUT (.clock(clock), .srst(srst), .cpu_tick(cpu_tick), .bus(bus),
    .rdata(rdata), .one_pin(one_pin), .zero_pin(zero_pin), .irq_req(irq_req));
  trp_pin_load one_load (.clock(clock), .clr(clr), .pin(one_pin),
    .high_cnt(one_high), .last_gap(one_gap));
  trp_pin_load zero_load (.clock(clock), .clr(clr), .pin(zero_pin),
    .high_cnt(zero_high), .last_gap(zero_gap));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cycles

  task automatic clear_load();
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
  endtask : clear_load

  // Stop, mask, clear, rate and source, values, function, then run
  task automatic setup(input logic one, input logic fast, input logic [7:0] mode,
    input logic [7:0] cnt, input logic [7:0] rel);
    logic [7:0] m;
    m = one ? 8'hdc : 8'hda;
    wr(m, 8'h00);
    wr(8'hc9, 8'h00);
    wr(8'hc8, 8'h00);
    wr(m, mode & 8'h74);
    wr(8'hd8, fast ? (one ? 8'h08 : 8'h04) : 8'h00);
    wr(one ? 8'hdd : 8'hdb, cnt);
    wr(one ? 8'hde : 8'hcd, rel);
    wr(m, mode & 8'h7f);
    wr(m, mode);
  endtask : setup

  task automatic t_reset();
    logic [7:0] a [6] = '{8'hdc, 8'hdd, 8'hde, 8'hda, 8'hcd, 8'h10};
    logic [7:0] v;
    check("pins idle", {one_pin, zero_pin, irq_req}, 16'h0000);
    foreach (a[i]) begin
      rd(a[i], v);
      check("reset read", v, 8'h00);
    end
    wr(8'hdc, 8'h7f);
    rd(8'hdc, v);
    check("mode readback", v, 8'h77);
    wr(8'hde, 8'h5a);
    rd(8'hde, v);
    check("reload write-only", v, 8'h00);
    wr(8'h10, 8'h33);
    rd(8'h10, v);
    check("unmapped", v, 8'h00);
    wr(8'hdc, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_duty();
    logic [16:0] tab [6] = '{{1'b1, 8'hf1, 8'h00}, {1'b1, 8'hf1, 8'h80},
      {1'b1, 8'hf1, 8'hff}, {1'b1, 8'hf5, 8'h30}, {1'b0, 8'hf1, 8'h02},
      {1'b0, 8'hf1, 8'hc0}};
    logic [7:0] v;
    foreach (tab[i]) begin
      setup(tab[i][16], 1'b1, tab[i][15:8], 8'h00, tab[i][7:0]);
      clear_load();
      cycles(512);
      check("pwm high", tab[i][16] ? one_high : zero_high, {7'h00, tab[i][7:0], 1'b0});
      check("pwm drive", tab[i][16] ? {one_pin.oe, one_pin.gpio_off}
        : {zero_pin.oe, zero_pin.gpio_off}, 16'h0003);
      rd(8'hc8, v);
      check("pwm flag", v & (tab[i][16] ? 8'h02 : 8'h01), tab[i][16] ? 8'h02 : 8'h01);
    end
    $display("test duty done");
  endtask : t_duty

  task automatic t_toggle();
    logic fast;
    logic [2:0] r;
    int t;
    for (int i = 0; i < 7; i++) begin
      fast = (i < 5);
      r = fast ? 3'(i + 3) : 3'(i + 1);
      t = fast ? 256 * (128 >> r) : 256 * (256 >> r) * 4;
      setup(1'b1, fast, {1'b1, r, 4'h2}, 8'h00, 8'h00);
      clear_load();
      cycles(t * 5 / 2);
      check("toggle gap", one_gap, 16'(t));
      check("toggle pin", {one_pin.oe, one_pin.gpio_off}, 16'h0003);
    end
    setup(1'b1, 1'b1, 8'hf6, 8'hc0, 8'hc0);
    clear_load();
    cycles(192);
    check("reload gap", one_gap, 16'h0040);
    setup(1'b0, 1'b1, 8'hf2, 8'h00, 8'h00);
    clear_load();
    cycles(640);
    check("zero toggle gap", zero_gap, 16'h0100);
    check("zero toggle pin", {zero_pin.oe, zero_pin.gpio_off}, 16'h0003);
    $display("test toggle done");
  endtask : t_toggle

  task automatic t_irq();
    logic [7:0] v;
    setup(1'b1, 1'b1, 8'hf0, 8'hf0, 8'h00);
    cycles(40);
    check("masked request", irq_req, 2'b00);
    rd(8'hc8, v);
    check("flag set", v & 8'h02, 8'h02);
    wr(8'hc9, 8'h02);
    #1 check("request", irq_req, 2'b10);
    wr(8'hc8, 8'h00);
    #1 check("request cleared", irq_req, 2'b00);
    $display("test irq done");
  endtask : t_irq

  task automatic t_stop();
    logic [7:0] a;
    logic [7:0] b;
    setup(1'b1, 1'b1, 8'hf1, 8'h00, 8'h80);
    cycles(20);
    check("pwm early high", one_pin.level, 1'b1);
    wr(8'hdd, 8'hf0);
    cycles(1);
    check("count write low", one_pin.level, 1'b0);
    wr(8'hdc, 8'h71);
    clear_load();
    cycles(64);
    check("stopped high", one_high, 16'h0000);
    rd(8'hdd, a);
    cycles(10);
    rd(8'hdd, b);
    check("stopped count", b, a);
    $display("test stop done");
  endtask : t_stop

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_duty();
    t_toggle();
    t_irq();
    t_stop();
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    complete_run();
  end
endmodule : timer_reload_toggle_pwm_tb
